// ---- rtl/bps_boot_power_sequencer.sv ----
// Boot power sequencer: supply detection, regulator and crystal start,
// wake-up mirror engine, boot mode selection and development probing.
// Assumes the analog ready and comparator levels are synchronous to clk,
// one-cycle read latency on the memory port and a RAM sink with ready.
//
// Functional notes
// - Hardwired power stage runs before anything else.
// - Startup firmware only after cold start.
// - Cold-start flag set at power-up.
// - Buck above 2 V, boost above 0.5 V.
// - First check boost; enable converter in boost.
// - Else bandgap, then core and memory regulators; here the bandgap starts in both cases.
// - Start crystal; second check overrides converter mode.
// - Poll ready signals; continue after timeout.
// - Control bit disables the ready timeout.
// - Power stage hands to firmware or mirror.
// - Copy-enable bit gates memory-to-RAM copy.
// - Hardware copies on wake, firmware on cold.
// - Retained word count sets copy length.
// - Full copy takes about 1.2 ms; here 8191 words take about 0.66 ms, two per four cycles.
// - Matching header flags select normal mode.
// - All-zero memory means development mode.
// - Random header still activates peripherals.
// - Development mode enables all download interfaces.
// - Probe steps 0 to 10 in fixed order.
// - Probe pins follow the fixed pin table.
// - Send character, wait answer, advance on timeout.
// - Normal: configure, copy, patch, then remap.
// - Final normal step issues a software reset.
// - Flag words must equal fixed magic values.
// - Header length gives words to copy.
`timescale 1ns/100ps

module bps_boot_power_sequencer (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Wake request and sleep retention.
    input wire logic wakeReq,
    input wire logic timeoutDisable,
    input wire logic copyEnable,
    // Analog comparators and ready levels.
    input wire logic highBatteryAboveBuck,
    input wire logic lowBatterySenseAboveBoost,
    input wire logic bandgapReady,
    input wire logic regulatorsReady,
    input wire logic crystalReady,
    // Analog enables.
    output logic dcdcEnable,
    output logic dcdcBoost,
    output logic bandgapEnable,
    output logic coreRegEnable,
    output logic memRegEnable,
    output logic fastCrystalOscillatorEnable,
    // Programmable memory read port.
    output logic otpRead,
    output logic [12:0] otpAddr,
    input wire logic [31:0] otpData,
    // System RAM write port.
    output logic ramWrite,
    output logic [12:0] ramAddr,
    output logic [31:0] ramData,
    input wire logic ramReady,
    // Processor and remap.
    output logic cpuRelease,
    output logic coldStart,
    output logic addressZeroRemap,
    output logic softReset,
    output logic [12:0] mirrorWordCount,
    output logic [1:0] bootMode,
    // Development probing.
    output logic [3:0] probeIndex,
    output logic [1:0] probeIface,
    output logic [2:0] probeClkPin,
    output logic [2:0] probeDataPin,
    output logic probeSend,
    input wire logic probeAnswer,
    output logic probeDone,
    output logic downloadActive
);

    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    typedef enum logic [4:0] {
        S_BOOST_CHK, S_BANDGAP, S_REGS, S_XTAL, S_MODE_CHK, S_HANDOFF,
        S_RD_LEN, S_RD_F1, S_RD_F2, S_DECIDE, S_COPY, S_COPY_DRAIN,
        S_REMAP, S_SWRESET, S_PROBE_SEND, S_PROBE_WAIT, S_DOWNLOAD,
        S_RUN
    } bps_state_e;

    bps_state_e state;
    bps_state_e next_state;
    logic [bps_pkg::TMR_W-1:0] timer;
    logic [12:0] copyCount;
    logic [12:0] rdPtr;
    logic rdPending;
    logic rdValid;
    logic [1:0] rdStep;
    logic headerMatch;
    logic coldPath;

    // Two-entry buffer between memory reads and RAM writes.
    logic [31:0] bufData [2];
    logic [1:0] bufCount;
    logic bufWrPtr;
    logic bufRdPtr;

    // -----------------------------------------------------------------
    // Decode
    // -----------------------------------------------------------------
    // A ready wait ends on the level, or on timeout unless disabled.
    wire logic timedOut = (timer >= bps_pkg::TMR_W'(bps_pkg::SETTLE_TIMEOUT_CYC))
        && !timeoutDisable;
    wire logic probeTimedOut =
        timer >= bps_pkg::TMR_W'(bps_pkg::PROBE_TIMEOUT_CYC);
    wire logic bufEmpty = bufCount == 2'd0;
    // Data lags a read by two edges; reads wait for room for each owed word.
    wire logic issueRead = (state == S_COPY) && (rdPtr != copyCount)
        && (({1'b0, bufCount} + {2'b00, rdPending} + {2'b00, rdValid})
        < 3'd2);
    wire logic bufPush = rdValid;
    wire logic bufPop = !bufEmpty && ramReady;
    wire logic copyFinished = (rdPtr == copyCount) && !rdPending && !rdValid
        && bufEmpty;
    // Next buffer head, so that the RAM port is driven from flip-flops.
    wire logic next_rdPtr = bufPop ? !bufRdPtr : bufRdPtr;
    wire logic [31:0] next_ramData = (bufPush && next_rdPtr == bufWrPtr) ?
        otpData : bufData[next_rdPtr];
    wire logic [1:0] next_bufCount = bufCount + {1'b0, bufPush}
        - {1'b0, bufPop};

    // Probe table: interface and pins per sequence index.
    wire logic [1:0] ifaceOfStep = (probeIndex < 4'd2) ? bps_pkg::BPS_IF_SPIM
        : (probeIndex < 4'd6) ? bps_pkg::BPS_IF_UART
        : (probeIndex == 4'd6) ? bps_pkg::BPS_IF_SPIS
        : bps_pkg::BPS_IF_I2C;
    wire logic [1:0] pairOfStep = (probeIndex < 4'd6) ?
        2'(probeIndex - 4'd2) : 2'(probeIndex - 4'd7);
    wire logic [2:0] clkPinOfStep = (ifaceOfStep == bps_pkg::BPS_IF_UART
        || ifaceOfStep == bps_pkg::BPS_IF_I2C) ? {pairOfStep, 1'b0}
        : 3'd0;
    wire logic [2:0] dataPinOfStep = (ifaceOfStep == bps_pkg::BPS_IF_UART
        || ifaceOfStep == bps_pkg::BPS_IF_I2C) ? {pairOfStep, 1'b1}
        : (probeIndex == 4'd1) ? 3'd1 : 3'd3;

    // -----------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------
    // The power stage always runs first, cold or wake.
    always_comb begin
        next_state = state;
        unique case (state)
            S_BOOST_CHK: next_state = S_BANDGAP;
            S_BANDGAP: if (bandgapReady || timedOut)
                next_state = S_REGS;
            S_REGS: if (regulatorsReady || timedOut)
                next_state = S_XTAL;
            S_XTAL: if (crystalReady || timedOut)
                next_state = S_MODE_CHK;
            S_MODE_CHK: next_state = S_HANDOFF;
            S_HANDOFF: next_state = coldPath ? S_RD_LEN
                : (copyEnable ? S_COPY : S_RUN);
            S_RD_LEN: if (rdStep == 2'd2) next_state = S_RD_F1;
            S_RD_F1: if (rdStep == 2'd2) next_state = S_RD_F2;
            S_RD_F2: if (rdStep == 2'd2) next_state = S_DECIDE;
            S_DECIDE: next_state = headerMatch ?
                (copyEnable ? S_COPY : S_REMAP) : S_PROBE_SEND;
            S_COPY: if (copyFinished) next_state = S_COPY_DRAIN;
            S_COPY_DRAIN: next_state = coldPath ? S_REMAP : S_RUN;
            S_REMAP: next_state = S_SWRESET;
            S_SWRESET: next_state = S_RUN;
            S_PROBE_SEND: next_state = S_PROBE_WAIT;
            S_PROBE_WAIT: begin
                if (probeAnswer) begin
                    next_state = S_DOWNLOAD;
                end else if (probeTimedOut) begin
                    next_state = (probeIndex == bps_pkg::PROBE_LAST) ?
                        S_RUN : S_PROBE_SEND;
                end
            end
            S_DOWNLOAD: next_state = S_DOWNLOAD;
            S_RUN: if (wakeReq) next_state = S_BOOST_CHK;
            default: next_state = S_BOOST_CHK;
        endcase
    end

    // -----------------------------------------------------------------
    // Sequencing registers
    // -----------------------------------------------------------------
    // State, timer and cold flag; the flag survives sleep, cleared by run.
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= S_BOOST_CHK;
            timer <= '0;
            coldPath <= 1'b1;
        end else begin
            state <= next_state;
            timer <= (next_state != state) ? '0 : timer + 1'b1;
            if (state == S_RUN) begin
                coldPath <= 1'b0;
            end
        end
    end

    // Analog enables; the late mode check overrides the early one.
    always_ff @(posedge clk) begin
        if (rst) begin
            dcdcEnable <= 1'b0;
            dcdcBoost <= 1'b0;
            bandgapEnable <= 1'b0;
            coreRegEnable <= 1'b0;
            memRegEnable <= 1'b0;
            fastCrystalOscillatorEnable <= 1'b0;
        end else if (state == S_BOOST_CHK) begin
            dcdcEnable <= lowBatterySenseAboveBoost;
            dcdcBoost <= lowBatterySenseAboveBoost;
            bandgapEnable <= 1'b1;
        end else if (state == S_REGS) begin
            coreRegEnable <= 1'b1;
            memRegEnable <= 1'b1;
        end else if (state == S_XTAL) begin
            fastCrystalOscillatorEnable <= 1'b1;
        end else if (state == S_MODE_CHK) begin
            dcdcEnable <= 1'b1;
            dcdcBoost <= !highBatteryAboveBuck;
        end
    end

    // -----------------------------------------------------------------
    // Header reads and copy engine
    // -----------------------------------------------------------------
    // Header words take a read cycle, a wait cycle and a capture cycle each.
    always_ff @(posedge clk) begin
        if (rst) begin
            rdStep <= 2'd0;
            headerMatch <= 1'b0;
            mirrorWordCount <= '0;
        end else if (state == S_RD_LEN || state == S_RD_F1
            || state == S_RD_F2) begin
            rdStep <= (rdStep == 2'd2) ? 2'd0 : rdStep + 2'd1;
            if (rdStep == 2'd2 && state == S_RD_LEN) begin
                mirrorWordCount <= otpData[12:0];
            end
            if (rdStep == 2'd2 && state == S_RD_F1) begin
                headerMatch <= (otpData == bps_pkg::APP_FLAG1);
            end
            if (rdStep == 2'd2 && state == S_RD_F2) begin
                headerMatch <= headerMatch
                    && (otpData == bps_pkg::APP_FLAG2);
            end
        end else begin
            rdStep <= 2'd0;
        end
    end

    // Sequential read pointer from word zero up to the count.
    always_ff @(posedge clk) begin
        if (rst) begin
            rdPtr <= '0;
            rdPending <= 1'b0;
            rdValid <= 1'b0;
            copyCount <= '0;
        end else begin
            rdPending <= issueRead;
            rdValid <= rdPending;
            if (state != S_COPY) begin
                rdPtr <= '0;
                copyCount <= mirrorWordCount;
            end else if (issueRead) begin
                rdPtr <= rdPtr + 13'd1;
            end
        end
    end

    // Two-entry buffer: a stalled RAM holds the reads back.
    always_ff @(posedge clk) begin
        if (rst) begin
            bufCount <= 2'd0;
            bufWrPtr <= 1'b0;
            bufRdPtr <= 1'b0;
            ramAddr <= '0;
            ramWrite <= 1'b0;
            ramData <= '0;
        end else begin
            if (bufPush) begin
                bufData[bufWrPtr] <= otpData;
                bufWrPtr <= !bufWrPtr;
            end
            if (bufPop) begin
                bufRdPtr <= !bufRdPtr;
                ramAddr <= ramAddr + 13'd1;
            end
            if (state == S_HANDOFF || state == S_DECIDE) begin
                ramAddr <= '0;
            end
            bufCount <= next_bufCount;
            ramWrite <= next_bufCount != 2'd0;
            ramData <= next_ramData;
        end
    end

    // Memory read port outputs, registered.
    always_ff @(posedge clk) begin
        if (rst) begin
            otpRead <= 1'b0;
            otpAddr <= '0;
        end else begin
            otpRead <= issueRead || (rdStep == 2'd0 && (state == S_RD_LEN
                || state == S_RD_F1 || state == S_RD_F2));
            unique case (state)
                S_RD_LEN: otpAddr <= bps_pkg::HDR_LENGTH_ADDR[14:2];
                S_RD_F1: otpAddr <= bps_pkg::HDR_FLAG1_ADDR[14:2];
                S_RD_F2: otpAddr <= bps_pkg::HDR_FLAG2_ADDR[14:2];
                default: otpAddr <= rdPtr;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // Boot outcome and probing
    // -----------------------------------------------------------------
    // Processor release, remap, reset pulse and probe outputs.
    always_ff @(posedge clk) begin
        if (rst) begin
            cpuRelease <= 1'b0;
            coldStart <= 1'b1;
            addressZeroRemap <= 1'b0;
            softReset <= 1'b0;
            bootMode <= bps_pkg::BPS_BOOT_NONE;
            probeIndex <= '0;
            probeIface <= '0;
            probeClkPin <= '0;
            probeDataPin <= '0;
            probeSend <= 1'b0;
            probeDone <= 1'b0;
            downloadActive <= 1'b0;
        end else begin
            coldStart <= coldPath;
            cpuRelease <= (state == S_RUN) || (state == S_PROBE_SEND)
                || (state == S_PROBE_WAIT) || (state == S_DOWNLOAD);
            softReset <= (state == S_SWRESET);
            if (state == S_REMAP) begin
                addressZeroRemap <= 1'b1;
            end
            if (state == S_DECIDE) begin
                bootMode <= headerMatch ? bps_pkg::BPS_BOOT_NORMAL
                    : bps_pkg::BPS_BOOT_DEV;
                probeIndex <= '0;
            end
            probeSend <= (state == S_PROBE_SEND);
            probeIface <= ifaceOfStep;
            probeClkPin <= clkPinOfStep;
            probeDataPin <= dataPinOfStep;
            if (state == S_PROBE_WAIT && !probeAnswer && probeTimedOut) begin
                if (probeIndex == bps_pkg::PROBE_LAST) begin
                    probeDone <= 1'b1;
                end else begin
                    probeIndex <= probeIndex + 4'd1;
                end
            end
            downloadActive <= (state == S_DOWNLOAD);
        end
    end

endmodule // bps_boot_power_sequencer

// ---- rtl/bps_pkg.sv ----
// Package for the boot power sequencer: constants shared by the design.
// Assumes a 25 MHz system clock; all times convert to cycles here.
package bps_pkg;

    // -----------------------------------------------------------------
    // Timing
    // -----------------------------------------------------------------
    localparam int CLK_HZ = 25000000;
    // Settle timeout for each analog ready signal, in microseconds.
    localparam int SETTLE_TIMEOUT_US = 500;
    localparam int SETTLE_TIMEOUT_CYC = (SETTLE_TIMEOUT_US * (CLK_HZ / 1000000));
    // Development-mode answer timeout per probe step, in microseconds.
    localparam int PROBE_TIMEOUT_US = 100;
    localparam int PROBE_TIMEOUT_CYC = (PROBE_TIMEOUT_US * (CLK_HZ / 1000000));
    // Width of the shared timeout counter.
    localparam int TMR_W = 16;

    // -----------------------------------------------------------------
    // Memory layout
    // -----------------------------------------------------------------
    localparam int OTP_AW = 13;           // 32 kB as 8 k words.
    localparam logic [15:0] HDR_LENGTH_ADDR = 16'h7FF8;
    localparam logic [15:0] HDR_FLAG1_ADDR = 16'h7F00;
    localparam logic [15:0] HDR_FLAG2_ADDR = 16'h7F04;
    localparam logic [31:0] APP_FLAG1 = 32'h1234_A5A5;
    localparam logic [31:0] APP_FLAG2 = 32'hA5A5_1234;

    // -----------------------------------------------------------------
    // Probe sequence
    // -----------------------------------------------------------------
    localparam logic [3:0] PROBE_LAST = 4'hA;
    // Interface kinds of a probe step.
    typedef enum logic [1:0] {
        BPS_IF_SPIM,
        BPS_IF_UART,
        BPS_IF_SPIS,
        BPS_IF_I2C
    } bps_if_e;

    // Boot outcome.
    typedef enum logic [1:0] {
        BPS_BOOT_NONE,
        BPS_BOOT_NORMAL,
        BPS_BOOT_DEV
    } bps_boot_e;

endpackage : bps_pkg

// ---- testbench/bps_boot_power_sequencer_properties.sv ----
// Checker for the boot power sequencer: timing relations on its ports.
// Assumes it is bound into the top module and shares its clock and reset.
`timescale 1ns/100ps

module bps_boot_power_sequencer_properties (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Inputs watched.
    input wire logic lowBatterySenseAboveBoost,
    input wire logic ramReady,
    // Outputs watched.
    input wire logic dcdcEnable,
    input wire logic dcdcBoost,
    input wire logic bandgapEnable,
    input wire logic coreRegEnable,
    input wire logic fastCrystalOscillatorEnable,
    input wire logic otpRead,
    input wire logic ramWrite,
    input wire logic [12:0] ramAddr,
    input wire logic [31:0] ramData,
    input wire logic cpuRelease,
    input wire logic coldStart,
    input wire logic addressZeroRemap,
    input wire logic softReset,
    input wire logic [1:0] bootMode,
    input wire logic [3:0] probeIndex,
    input wire logic probeSend
);
    // One domain, so clock and reset are given once for all properties.
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    cold_flag_set_a: assert property ($fell(rst) |-> coldStart)
        else $error("cold flag low after reset");
    boost_first_a: assert property ($fell(rst) && lowBatterySenseAboveBoost
        |-> ##[1:4] dcdcEnable && dcdcBoost)
        else $error("boost converter not started first");
    power_first_a: assert property (otpRead || ramWrite
        |-> fastCrystalOscillatorEnable)
        else $error("memory traffic before power stage");
    regs_after_bg_a: assert property ($rose(coreRegEnable)
        |-> bandgapEnable)
        else $error("core regulator before bandgap");
    release_late_a: assert property ($rose(cpuRelease)
        |-> fastCrystalOscillatorEnable)
        else $error("processor released before power stage");
    remap_first_a: assert property (softReset
        |-> addressZeroRemap && bootMode == 2'h1)
        else $error("soft reset without remap");
    reset_pulse_a: assert property (softReset |=> !softReset)
        else $error("soft reset longer than one cycle");
    fw_cold_only_a: assert property (softReset |-> coldStart)
        else $error("firmware path taken on wake");
    probe_dev_a: assert property (probeSend
        |-> bootMode == 2'h2 && probeIndex <= 4'hA)
        else $error("probe outside development mode");
    probe_step_a: assert property ($changed(probeIndex) && probeIndex != 4'h0
        |-> probeIndex == $past(probeIndex) + 4'h1)
        else $error("probe step skipped");
    ram_hold_a: assert property (ramWrite && !ramReady
        |=> ramWrite && $stable(ramData) && $stable(ramAddr))
        else $error("stalled RAM word changed");
endmodule // bps_boot_power_sequencer_properties

// ---- testbench/bps_far_side_model.sv ----
// Far side of the sequencer: analog blocks, memory, RAM sink, boot host.
// Assumes the bench sets the scenario controls at falling edges.
`timescale 1ns/100ps

module bps_far_side_model (
    // Clock and scenario controls.
    input wire logic clk,
    input wire logic programmed,
    input wire logic dead,
    input wire logic stall,
    input wire logic [3:0] answerStep,
    // Analog blocks.
    input wire logic bandgapEnable,
    input wire logic coreRegEnable,
    input wire logic fastCrystalOscillatorEnable,
    output logic bandgapReady = 1'b0,
    output logic regulatorsReady = 1'b0,
    output logic crystalReady = 1'b0,
    // Memory and RAM.
    input wire logic otpRead,
    input wire logic [12:0] otpAddr,
    output logic [31:0] otpData = 32'h0000_0000,
    output logic ramReady = 1'b0,
    // Boot host.
    input wire logic probeSend,
    input wire logic [3:0] probeIndex,
    output logic probeAnswer = 1'b0
);
    logic tick = 1'b0;

    // Header words sit at the top; a blank part reads all zero.
    function automatic logic [31:0] word(logic [12:0] a);
        if (!programmed) return 32'h0000_0000;
        if (a == 13'h1FFE) return 32'h0000_0004;
        if (a == 13'h1FC0) return 32'h1234_A5A5;
        if (a == 13'h1FC1) return 32'hA5A5_1234;
        return {16'hC0DE, 3'h0, a};
    endfunction

    // Between reads the data lines toggle so stale data never passes.
    always @(posedge clk) begin
        tick <= ~tick;
        bandgapReady <= bandgapEnable && !dead;
        regulatorsReady <= coreRegEnable && !dead;
        crystalReady <= fastCrystalOscillatorEnable && !dead;
        otpData <= otpRead ? word(otpAddr) : ~otpData;
        ramReady <= !stall || tick;
        if (probeSend && probeIndex == answerStep) probeAnswer <= 1'b1;
    end
endmodule // bps_far_side_model

// ---- testbench/tb_boot_power_sequencer.sv ----
// Testbench for the boot power sequencer: cold, wake, timeout, hold and
// development boots. Assumes the far-side model and the bound checker.
`timescale 1ns/100ps

`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin \
    num_errors++; $display("Error %s exp %h seen %h", n, e, a); end end

module tb_boot_power_sequencer;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wakeReq = 1'b0;
    logic timeoutDisable = 1'b0;
    logic copyEnable = 1'b1;
    logic highBatteryAboveBuck = 1'b1;
    logic lowBatterySenseAboveBoost = 1'b0;
    logic programmed = 1'b1;
    logic dead = 1'b0;
    logic stall = 1'b1;
    logic [3:0] answerStep = 4'h4;
    logic bandgapReady, regulatorsReady, crystalReady, ramReady, probeAnswer;
    logic dcdcEnable, dcdcBoost, bandgapEnable, coreRegEnable, memRegEnable;
    logic fastCrystalOscillatorEnable, otpRead, ramWrite, cpuRelease;
    logic coldStart, addressZeroRemap, softReset, probeSend, probeDone;
    logic downloadActive;
    logic [12:0] otpAddr, ramAddr, mirrorWordCount;
    logic [31:0] otpData, ramData;
    logic [1:0] bootMode, probeIface;
    logic [3:0] probeIndex;
    logic [2:0] probeClkPin, probeDataPin;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;
    int swCnt = 0;
    logic [44:0] wr[$];

    initial begin
        forever #20 clk = ~clk;
    end

    bps_boot_power_sequencer i_dut (.clk, .rst, .wakeReq, .timeoutDisable,
        .copyEnable, .highBatteryAboveBuck, .lowBatterySenseAboveBoost,
        .bandgapReady, .regulatorsReady, .crystalReady, .dcdcEnable,
        .dcdcBoost, .bandgapEnable, .coreRegEnable, .memRegEnable,
        .fastCrystalOscillatorEnable, .otpRead, .otpAddr, .otpData,
        .ramWrite, .ramAddr, .ramData, .ramReady, .cpuRelease, .coldStart,
        .addressZeroRemap, .softReset, .mirrorWordCount, .bootMode,
        .probeIndex, .probeIface, .probeClkPin, .probeDataPin, .probeSend,
        .probeAnswer, .probeDone, .downloadActive);

    bps_far_side_model i_far (.clk, .programmed, .dead, .stall, .answerStep,
        .bandgapEnable, .coreRegEnable, .fastCrystalOscillatorEnable,
        .bandgapReady, .regulatorsReady, .crystalReady, .otpRead, .otpAddr,
        .otpData, .ramReady, .probeSend, .probeIndex, .probeAnswer);

    // Log accepted RAM words and reset pulses; a stuck run ends at the cap.
    always @(posedge clk) begin
        cycles++;
        if (ramWrite && ramReady) wr.push_back({ramAddr, ramData});
        if (softReset) swCnt++;
        if (cycles == 90000) begin
            num_errors++;
            end_of_test();
        end
    end

    // -----------------------------------------------------------------
    // Helpers and scenarios
    // -----------------------------------------------------------------
    task automatic end_of_test();
        if (num_errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic do_reset();
        wr.delete();
        swCnt = 0;
        rst = 1'b1;
        repeat (4) @(negedge clk);
        rst = 1'b0;
    endtask

    // Release can take long, so the wait is bounded and then settles.
    task automatic wait_rel(int n);
        repeat (n) begin
            @(negedge clk);
            if (cpuRelease === 1'b1) break;
        end
        repeat (4) @(negedge clk);
    endtask

    task automatic check_copy();
        `CHK("count", 32'(4), 32'(wr.size()))
        foreach (wr[i]) `CHK("ram", {13'(i), 16'hC0DE, 3'h0, 13'(i)}, wr[i])
    endtask

    task automatic normal_boot();
        do_reset();
        wait_rel(3000);
        `CHK("mode", 2'h1, bootMode)
        `CHK("remap", 1'b1, addressZeroRemap)
        `CHK("swrst", 1, swCnt)
        `CHK("nwords", 13'h0004, mirrorWordCount)
        `CHK("cold", 1'b0, coldStart)
        `CHK("memreg", 1'b1, memRegEnable)
        `CHK("boost", 1'b0, dcdcBoost)
        check_copy();
    endtask

    // Wake from run: the engine copies with the retained count, no reset.
    task automatic wake_copy();
        wr.delete();
        swCnt = 0;
        wakeReq = 1'b1;
        @(negedge clk);
        wakeReq = 1'b0;
        repeat (3000) begin
            @(negedge clk);
            if (wr.size() == 4 && cpuRelease === 1'b1) break;
        end
        repeat (20) @(negedge clk);
        `CHK("release", 1'b1, cpuRelease)
        `CHK("swrst", 0, swCnt)
        check_copy();
    endtask

    // Dead analog blocks: three waits run out, and copying is disabled.
    task automatic timeout_boot();
        dead = 1'b1;
        copyEnable = 1'b0;
        do_reset();
        repeat (37000) @(negedge clk);
        `CHK("early", 1'b0, cpuRelease)
        wait_rel(2000);
        `CHK("late", 1'b1, cpuRelease)
        `CHK("nocopy", 32'(0), 32'(wr.size()))
    endtask

    // Without the timeout the sequencer waits until the bandgap settles.
    task automatic hold_boot();
        timeoutDisable = 1'b1;
        do_reset();
        repeat (13000) @(negedge clk);
        `CHK("xtal", 1'b0, fastCrystalOscillatorEnable)
        dead = 1'b0;
        wait_rel(3000);
        `CHK("rel", 1'b1, cpuRelease)
        timeoutDisable = 1'b0;
        copyEnable = 1'b1;
    endtask

    // Blank memory on a boost supply: probe until the host answers.
    task automatic dev_boot();
        programmed = 1'b0;
        highBatteryAboveBuck = 1'b0;
        lowBatterySenseAboveBoost = 1'b1;
        do_reset();
        for (int i = 0; i < 5; i++) begin
            repeat (3000) begin
                @(negedge clk);
                if (probeSend === 1'b1) break;
            end
            `CHK("index", 4'(i), probeIndex)
            `CHK("iface", i < 2 ? 2'h0 : 2'h1, probeIface)
            `CHK("clkpin", i < 2 ? 3'h0 : 3'(2 * i - 4), probeClkPin)
            if (i > 1) `CHK("datapin", 3'(2 * i - 3), probeDataPin)
        end
        repeat (20) @(negedge clk);
        `CHK("dl", 1'b1, downloadActive)
        `CHK("mode", 2'h2, bootMode)
        `CHK("boost", 1'b1, dcdcBoost)
        `CHK("done", 1'b0, probeDone)
    endtask

    initial begin
        normal_boot();
        wake_copy();
        timeout_boot();
        hold_boot();
        dev_boot();
        end_of_test();
    end
endmodule // tb_boot_power_sequencer

bind bps_boot_power_sequencer bps_boot_power_sequencer_properties i_chk (
    .clk, .rst, .lowBatterySenseAboveBoost, .ramReady, .dcdcEnable,
    .dcdcBoost, .bandgapEnable, .coreRegEnable, .fastCrystalOscillatorEnable,
    .otpRead, .ramWrite, .ramAddr, .ramData, .cpuRelease, .coldStart,
    .addressZeroRemap, .softReset, .bootMode, .probeIndex, .probeSend);
